// >>> velramp_pkg.sv
// Purpose: shared constants and types for the velocity ramp and speed status block
// Assumes: 100 MHz CLK, speeds in signed r/min, times in ms
// Notes: register map sits in the low byte of the AHB-Lite address
`default_nettype none
package velramp_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_REACH = 8'h04;
   localparam logic [7:0] A_MATCH = 8'h08;
   localparam logic [7:0] A_ACCEL = 8'h0C;
   localparam logic [7:0] A_DECEL = 8'h10;
   localparam logic [7:0] A_SCURVE = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   localparam logic [7:0] A_VREF = 8'h1C;
   // field positions
   localparam int CTRL_TORQUE_BIT = 0;
   localparam int CTRL_RAWCMP_BIT = 1;
   localparam int STAT_REACH_BIT = 0;
   localparam int STAT_MATCH_BIT = 1;
   localparam int STAT_LIMIT_BIT = 2;
   // reset values
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [15:0] RST_REACH = 16'h0032;
   localparam logic [15:0] RST_MATCH = 16'h0032;
   localparam logic [15:0] RST_ACCEL = 16'h0000;
   localparam logic [15:0] RST_DECEL = 16'h0000;
   localparam logic [15:0] RST_SCURVE = 16'h0000;
   // speed figures
   localparam logic [16:0] HYST_RPM = 17'h0000A;
   localparam logic [31:0] RAMP_REF_RPM = 32'h000003E8;
   localparam logic [17:0] LIM_SPAN_MAX = 18'h04E20;
   localparam logic [17:0] LIM_NUM = 18'h00006;
   localparam logic [17:0] LIM_DEN = 18'h00005;
   // smoothing filter
   localparam int SC_TAPS = 16;
   localparam int SC_SHIFT = 4;
   // bus
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {R_HOLD = 2'h0, R_ACC = 2'h1, R_DEC = 2'h3} ramp_st_t;
   typedef struct packed {
      logic signed [15:0] vel;
      logic signed [15:0] torque;
      logic [15:0] lim;
   } cmd_t;
   typedef struct packed {
      logic [15:0] os1;
      logic [15:0] os2;
      logic [15:0] mmax;
   } lim_cfg_t;
endpackage
`default_nettype wire

// >>> velocity_ramp_speed_status.sv
// Purpose: velocity command ramp with S-curve, speed reached / match flags, speed limit
// Assumes: command and feedback inputs come from logic on CLK, no synchroniser needed
// Notes: registers over AHB-Lite, zero wait states, word access only
`timescale 1ns/1ps
`default_nettype none
module velocity_ramp_speed_status
   import velramp_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
   input wire logic CLK, // control clock
   input wire logic RESET, // sync reset, high
   input wire logic CE, // clock enable, freezes state
   input wire logic HSEL, // slave select
   input wire logic [31:0] HADDR, // address
   input wire logic [1:0] HTRANS, // transfer type
   input wire logic HWRITE, // write
   input wire logic [2:0] HSIZE, // size, word only
   input wire logic [31:0] HWDATA, // write data
   input wire logic HREADY, // bus ready
   output logic [31:0] HRDATA, // read data
   output logic HREADYOUT, // slave ready
   output logic HRESP, // always okay
   input wire velramp_pkg::cmd_t CMD, // host commands
   input wire velramp_pkg::lim_cfg_t LIM_CFG, // overspeed levels, motor max
   input wire logic signed [15:0] MOTOR_SPEED, // measured speed r/min
   output logic signed [15:0] VEL_REF, // ramped, smoothed velocity
   output logic signed [15:0] TORQUE_REF, // torque after limiting
   output logic SPEED_REACHED, // speed_reached_flag
   output logic SPEED_MATCH, // speed_match_flag
   output logic SPD_LIMITING // speed limit active
);
   import velramp_pkg::*;

   function automatic logic [16:0] abs17(input logic signed [16:0] v);
      abs17 = v[16] ? 17'(-v) : 17'(v);
   endfunction

   // register file state
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [15:0] reach_r, reach_nxt, match_r, match_nxt;
   logic [15:0] accel_r, accel_nxt, decel_r, decel_nxt, scurve_r, scurve_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_addr_r, wr_addr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ready_r;
   logic accept;
   // ramp state
   ramp_st_t ramp_st_r, ramp_st_nxt;
   logic signed [15:0] ramp_r, ramp_nxt;
   logic [31:0] acc_r, acc_nxt;
   logic [31:0] acc_sum, thr;
   logic [15:0] t_ms;
   logic accel_dir;
   // smoothing state
   logic signed [15:0] sc_mem_r [SC_TAPS];
   logic signed [15:0] sc_mem_nxt [SC_TAPS];
   logic [3:0] sc_idx_r, sc_idx_nxt;
   logic [31:0] sc_cnt_r, sc_cnt_nxt, sc_thr;
   logic signed [19:0] sc_sum_r, sc_sum_nxt;
   logic signed [15:0] vref_r, vref_nxt;
   // flag state
   logic reached_r, reached_nxt, match_f_r, match_f_nxt, limit_r, limit_nxt;
   logic signed [15:0] torque_r, torque_nxt;
   logic [16:0] spd_abs, diff_abs;
   logic signed [15:0] cmp_vel;
   logic [17:0] lim_mx, lim_eff;
   logic push;

   assign accept = HSEL && HTRANS[1] && HREADY;

   // bus slave: address phase captured, write lands in data phase
   always_comb begin
      ctrl_nxt = ctrl_r;
      reach_nxt = reach_r;
      match_nxt = match_r;
      accel_nxt = accel_r;
      decel_nxt = decel_r;
      scurve_nxt = scurve_r;
      wr_pend_nxt = accept && HWRITE;
      wr_addr_nxt = HADDR[7:0];
      rdata_nxt = 32'h00000000;
      if (wr_pend_r) begin
         unique case (wr_addr_r)
            A_CTRL: ctrl_nxt = HWDATA[1:0];
            A_REACH: reach_nxt = HWDATA[15:0];
            A_MATCH: match_nxt = HWDATA[15:0];
            A_ACCEL: accel_nxt = HWDATA[15:0];
            A_DECEL: decel_nxt = HWDATA[15:0];
            A_SCURVE: scurve_nxt = HWDATA[15:0];
            default: ;
         endcase
      end
      // read from next values so a read right after a write sees it
      if (accept && !HWRITE) begin
         unique case (HADDR[7:0])
            A_CTRL: rdata_nxt = {30'h00000000, ctrl_nxt};
            A_REACH: rdata_nxt = {16'h0000, reach_nxt};
            A_MATCH: rdata_nxt = {16'h0000, match_nxt};
            A_ACCEL: rdata_nxt = {16'h0000, accel_nxt};
            A_DECEL: rdata_nxt = {16'h0000, decel_nxt};
            A_SCURVE: rdata_nxt = {16'h0000, scurve_nxt};
            A_STATUS: rdata_nxt = {29'h00000000, limit_r, match_f_r, reached_r};
            A_VREF: rdata_nxt = {{16{vref_r[15]}}, vref_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_r <= RST_CTRL;
         reach_r <= RST_REACH;
         match_r <= RST_MATCH;
         accel_r <= RST_ACCEL;
         decel_r <= RST_DECEL;
         scurve_r <= RST_SCURVE;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rdata_r <= 32'h00000000;
         ready_r <= 1'b1;
      end else if (CE) begin
         ctrl_r <= ctrl_nxt;
         reach_r <= reach_nxt;
         match_r <= match_nxt;
         accel_r <= accel_nxt;
         decel_r <= decel_nxt;
         scurve_r <= scurve_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         rdata_r <= rdata_nxt;
         ready_r <= 1'b1;
      end
   end

   // linear ramp: one r/min step each time the accumulator passes thr
   always_comb begin
      accel_dir = (ramp_r >= 0 && CMD.vel > ramp_r) || (ramp_r <= 0 && CMD.vel < ramp_r);
      t_ms = accel_dir ? accel_r : decel_r;
      thr = 32'(t_ms) * 32'(CYC_PER_MS);
      acc_sum = acc_r + RAMP_REF_RPM;
      ramp_nxt = ramp_r;
      acc_nxt = acc_r;
      ramp_st_nxt = R_HOLD;
      if (CMD.vel == ramp_r) begin
         acc_nxt = 32'h00000000;
      end else if (t_ms == 16'h0000) begin
         ramp_nxt = CMD.vel;
         acc_nxt = 32'h00000000;
      end else begin
         ramp_st_nxt = accel_dir ? R_ACC : R_DEC;
         if (acc_sum >= thr) begin
            // 1000 steps of thr/1000 cycles each span exactly t_ms per 1000 r/min
            acc_nxt = acc_sum - thr;
            ramp_nxt = (CMD.vel > ramp_r) ? 16'(ramp_r + 16'sh0001) : 16'(ramp_r - 16'sh0001);
         end else begin
            acc_nxt = acc_sum;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ramp_st_r <= R_HOLD;
         ramp_r <= 16'sh0000;
         acc_r <= 32'h00000000;
      end else if (CE) begin
         ramp_st_r <= ramp_st_nxt;
         ramp_r <= ramp_nxt;
         acc_r <= acc_nxt;
      end
   end

   // s-curve: 16-tap boxcar over scurve_time; a boxcar of a linear ramp
   // rounds each corner symmetrically about it, at the cost of scurve/2 lag
   always_comb begin
      sc_thr = (32'(scurve_r) * 32'(CYC_PER_MS)) >> SC_SHIFT;
      if (sc_thr == 32'h00000000) begin
         sc_thr = 32'h00000001;
      end
      sc_mem_nxt = sc_mem_r;
      sc_idx_nxt = sc_idx_r;
      sc_cnt_nxt = sc_cnt_r;
      sc_sum_nxt = sc_sum_r;
      if (scurve_r == 16'h0000) begin
         // keep taps primed so switching smoothing on gives no jump
         for (int i = 0; i < SC_TAPS; i++) begin
            sc_mem_nxt[i] = ramp_r;
         end
         sc_sum_nxt = 20'(ramp_r) <<< SC_SHIFT;
         sc_cnt_nxt = 32'h00000000;
         vref_nxt = ramp_r;
      end else begin
         if (sc_cnt_r + 32'h00000001 >= sc_thr) begin
            sc_cnt_nxt = 32'h00000000;
            sc_sum_nxt = sc_sum_r + 20'(ramp_r) - 20'(sc_mem_r[sc_idx_r]);
            sc_mem_nxt[sc_idx_r] = ramp_r;
            sc_idx_nxt = sc_idx_r + 4'h1;
         end else begin
            sc_cnt_nxt = sc_cnt_r + 32'h00000001;
         end
         vref_nxt = 16'(sc_sum_r >>> SC_SHIFT);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int i = 0; i < SC_TAPS; i++) begin
            sc_mem_r[i] <= 16'sh0000;
         end
         sc_idx_r <= 4'h0;
         sc_cnt_r <= 32'h00000000;
         sc_sum_r <= 20'sh00000;
         vref_r <= 16'sh0000;
      end else if (CE) begin
         sc_mem_r <= sc_mem_nxt;
         sc_idx_r <= sc_idx_nxt;
         sc_cnt_r <= sc_cnt_nxt;
         sc_sum_r <= sc_sum_nxt;
         vref_r <= vref_nxt;
      end
   end

   // status flags and speed limit
   always_comb begin
      spd_abs = abs17(17'(MOTOR_SPEED));
      cmp_vel = ctrl_r[CTRL_RAWCMP_BIT] ? CMD.vel : vref_r;
      diff_abs = abs17(17'(17'(cmp_vel) - 17'(MOTOR_SPEED)));
      reached_nxt = reached_r;
      if (spd_abs > 17'(reach_r)) begin
         reached_nxt = 1'b1;
      end else if (spd_abs + HYST_RPM < 17'(reach_r)) begin
         reached_nxt = 1'b0;
      end
      match_f_nxt = match_f_r;
      if (diff_abs + HYST_RPM <= 17'(match_r)) begin
         match_f_nxt = 1'b1;
      end else if (diff_abs >= 17'(match_r) + HYST_RPM) begin
         match_f_nxt = 1'b0;
      end
      // smallest of host limit, span, both overspeed levels, 1.2x max
      // widened product: 6x a 16-bit maximum overflows 18 bits before the divide
      lim_mx = 18'((20'(LIM_CFG.mmax) * 20'(LIM_NUM)) / 20'(LIM_DEN));
      lim_eff = {2'h0, CMD.lim};
      if (lim_eff > LIM_SPAN_MAX) lim_eff = LIM_SPAN_MAX;
      if (lim_eff > {2'h0, LIM_CFG.os1}) lim_eff = {2'h0, LIM_CFG.os1};
      if (lim_eff > {2'h0, LIM_CFG.os2}) lim_eff = {2'h0, LIM_CFG.os2};
      if (lim_eff > lim_mx) lim_eff = lim_mx;
      push = (CMD.torque > 0 && MOTOR_SPEED > 0) || (CMD.torque < 0 && MOTOR_SPEED < 0);
      limit_nxt = ctrl_r[CTRL_TORQUE_BIT] && ({1'b0, spd_abs} >= lim_eff);
      // withholding accelerating torque at the limit; small overshoot possible
      if (!ctrl_r[CTRL_TORQUE_BIT]) begin
         torque_nxt = 16'sh0000;
      end else if (limit_nxt && push) begin
         torque_nxt = 16'sh0000;
      end else begin
         torque_nxt = CMD.torque;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         reached_r <= 1'b0;
         match_f_r <= 1'b0;
         limit_r <= 1'b0;
         torque_r <= 16'sh0000;
      end else if (CE) begin
         reached_r <= reached_nxt;
         match_f_r <= match_f_nxt;
         limit_r <= limit_nxt;
         torque_r <= torque_nxt;
      end
   end

   assign HRDATA = rdata_r;
   assign HREADYOUT = ready_r;
   assign HRESP = 1'b0;
   assign VEL_REF = vref_r;
   assign TORQUE_REF = torque_r;
   assign SPEED_REACHED = reached_r;
   assign SPEED_MATCH = match_f_r;
   assign SPD_LIMITING = limit_r;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   property p_reach_on;
      CE && spd_abs > 17'(reach_r) |=> SPEED_REACHED;
   endproperty
   a_reach_on: assert property (p_reach_on) else $error("reached flag not set");

   property p_reach_hyst;
      CE && SPEED_REACHED && (spd_abs + HYST_RPM >= 17'(reach_r)) |=> SPEED_REACHED;
   endproperty
   a_reach_hyst: assert property (p_reach_hyst) else $error("reached flag dropped in band");

   property p_match_off;
      CE && diff_abs >= 17'(match_r) + HYST_RPM |=> !SPEED_MATCH;
   endproperty
   a_match_off: assert property (p_match_off) else $error("match flag stayed on");

   property p_match_on;
      CE && diff_abs + HYST_RPM <= 17'(match_r) |=> SPEED_MATCH;
   endproperty
   a_match_on: assert property (p_match_on) else $error("match flag not set");

   property p_ramp_step;
      CE && accel_r != 16'h0000 && decel_r != 16'h0000
         |=> (ramp_r - $past(ramp_r) <= 16'sh0001) && ($past(ramp_r) - ramp_r <= 16'sh0001);
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("ramp stepped more than 1");

   property p_ramp_bypass;
      CE && accel_r == 16'h0000 && decel_r == 16'h0000 |=> ramp_r == $past(CMD.vel);
   endproperty
   a_ramp_bypass: assert property (p_ramp_bypass) else $error("zero time ramp not bypassed");

   property p_scurve_bypass;
      CE && scurve_r == 16'h0000 |=> VEL_REF == $past(ramp_r);
   endproperty
   a_scurve_bypass: assert property (p_scurve_bypass) else $error("smoothing not bypassed");

   property p_torque_lim;
      CE && ctrl_r[CTRL_TORQUE_BIT] && {1'b0, spd_abs} >= lim_eff && push |=> TORQUE_REF == 16'sh0000;
   endproperty
   a_torque_lim: assert property (p_torque_lim) else $error("torque not cut at limit");

   property p_lim_clamp;
      CE |-> lim_eff <= {2'h0, LIM_CFG.os1} && lim_eff <= {2'h0, LIM_CFG.os2} && lim_eff <= lim_mx;
   endproperty
   a_lim_clamp: assert property (p_lim_clamp) else $error("limit above clamp");
endmodule
`default_nettype wire

// >>> host_cmd_model.sv
// Purpose: host motion controller model sending cyclic commands
// Assumes: same clock as the block, one frame every PERIOD cycles
// Notes: targets are set by the bench; the frame copies them whole
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model
   import velramp_pkg::*;
#(
   parameter int PERIOD = 4
) (
   input wire logic clk, // control clock
   input wire logic reset, // sync reset, high
   input wire logic signed [15:0] vel_tgt, // next velocity
   input wire logic signed [15:0] trq_tgt, // next torque
   input wire logic [15:0] lim_tgt, // next speed limit
   output velramp_pkg::cmd_t cmd // command frame
);
   import velramp_pkg::*;
   int cnt;

   // a fresh frame each period, so the block sees commands late by up to PERIOD
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt <= 0;
         cmd <= '0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         if (cnt == 0) begin
            cmd.vel <= vel_tgt;
            cmd.torque <= trq_tgt;
            cmd.lim <= lim_tgt;
         end
      end
   end
endmodule
`default_nettype wire

// >>> velocity_ramp_speed_status_tb.sv
// Purpose: self-checking bench for the velocity ramp and speed status block
// Assumes: CYC_PER_MS of 1000, so one ms lasts 1000 cycles
// Notes: register access through AHB-Lite tasks, speed driven directly
`timescale 1ns/1ps
`default_nettype none
module velocity_ramp_speed_status_tb;
   import velramp_pkg::*;
   logic clk = 0, reset = 1, hsel = 0, hwrite = 0;
   logic [31:0] haddr = '0, hwdata = '0, q;
   logic [1:0] htrans = '0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, reached, match, limiting;
   logic signed [15:0] vel_t = 0, trq_t = 0, speed = 0, vel_ref, trq_ref;
   logic [15:0] lim_t = '0;
   lim_cfg_t lim_cfg = '0;
   cmd_t cmd;
   int miscompares = 0, comparisons = 0, cycles = 0;

   always #5 clk = ~clk;

   host_cmd_model host_u (.clk(clk), .reset(reset), .vel_tgt(vel_t), .trq_tgt(trq_t),
      .lim_tgt(lim_t), .cmd(cmd));

   velocity_ramp_speed_status #(.CYC_PER_MS(1000)) dut_u (.CLK(clk), .RESET(reset),
      .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .CMD(cmd), .LIM_CFG(lim_cfg),
      .MOTOR_SPEED(speed), .VEL_REF(vel_ref), .TORQUE_REF(trq_ref),
      .SPEED_REACHED(reached), .SPEED_MATCH(match), .SPD_LIMITING(limiting));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // hang guard, well above the roughly 24k cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares = miscompares + 1;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one single transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h00000000);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   function automatic logic near(input logic signed [15:0] v, input int lo, input int hi);
      return (int'(v) >= lo) && (int'(v) <= hi);
   endfunction

   initial begin
      cyc(3);
      reset <= 1'b0;
      @(posedge clk);
      // reset values and access kinds
      rd(A_REACH); chk("reach rst", q, 32'h00000032);
      rd(A_MATCH); chk("match rst", q, 32'h00000032);
      rd(A_CTRL); chk("ctrl rst", q, 32'h00000000);
      rd(8'h20); chk("unmapped", q, 32'h00000000);
      wr(A_ACCEL, 32'h00000000);
      wr(A_DECEL, 32'h00000000);
      chk("hresp", {31'h0, hresp}, 32'h00000000);
      chk("hready", {31'h0, hreadyout}, 32'h00000001);
      $display("test registers done");
      // reached flag with hysteresis
      wr(A_REACH, 32'h00000064);
      speed <= 16'sd101; cyc(3);
      chk("reached on", {31'h0, reached}, 32'h00000001);
      speed <= 16'sd95; cyc(3);
      rd(A_STATUS); chk("reached held", q[STAT_REACH_BIT], 32'h00000001);
      speed <= 16'sd89; cyc(3);
      chk("reached off", {31'h0, reached}, 32'h00000000);
      $display("test reached done");
      // step passes through unramped
      vel_t <= 16'sd300; cyc(8);
      chk("step", {16'h0, vel_ref}, 32'h0000012C);
      // 300 down to 100 at 20 ms per 1000 r/min: 4000 cycles
      wr(A_DECEL, 32'h00000014);
      wr(A_ACCEL, 32'h0000000A);
      vel_t <= 16'sd100; cyc(2000);
      chk("decel mid", {31'h0, near(vel_ref, 196, 204)}, 32'h00000001);
      cyc(2100);
      chk("decel end", {16'h0, vel_ref}, 32'h00000064);
      rd(A_VREF); chk("vref reg", q, 32'h00000064);
      rd(A_ACCEL); chk("accel reg", q, 32'h0000000A);
      // 100 up to 300 at 10 ms per 1000 r/min: 2000 cycles
      vel_t <= 16'sd300; cyc(1000);
      chk("accel mid", {31'h0, near(vel_ref, 196, 204)}, 32'h00000001);
      cyc(1100);
      chk("accel end", {16'h0, vel_ref}, 32'h0000012C);
      $display("test ramp done");
      // 16 ms smoothing on a plain step
      wr(A_ACCEL, 32'h00000000);
      wr(A_DECEL, 32'h00000000);
      wr(A_SCURVE, 32'h00000010);
      vel_t <= 16'sd0; cyc(8000);
      chk("scurve mid", {31'h0, near(vel_ref, 50, 250)}, 32'h00000001);
      cyc(9500);
      chk("scurve end", {16'h0, vel_ref}, 32'h00000000);
      wr(A_SCURVE, 32'h00000000);
      $display("test scurve done");
      // match window 50, slow ramp keeps ramped command far behind
      wr(A_ACCEL, 32'h000003E8);
      wr(A_CTRL, 32'h00000002);
      vel_t <= 16'sd500;
      speed <= 16'sd460; cyc(8);
      chk("match on", {31'h0, match}, 32'h00000001);
      speed <= 16'sd445; cyc(3);
      chk("match held", {31'h0, match}, 32'h00000001);
      speed <= 16'sd440; cyc(3);
      chk("match off", {31'h0, match}, 32'h00000000);
      speed <= 16'sd500; cyc(3);
      rd(A_STATUS); chk("match raw", q[STAT_MATCH_BIT], 32'h00000001);
      wr(A_CTRL, 32'h00000000); cyc(3);
      chk("match ramped", {31'h0, match}, 32'h00000000);
      $display("test match done");
      // torque mode limit: min of 1000, 2000, 800, 1200 is 800
      lim_cfg <= '{os1: 16'h07D0, os2: 16'h0320, mmax: 16'h03E8};
      lim_t <= 16'h03E8;
      trq_t <= 16'sd50;
      wr(A_CTRL, 32'h00000001);
      speed <= 16'sd799; cyc(8);
      chk("below limit", {31'h0, limiting}, 32'h00000000);
      chk("torque pass", {16'h0, trq_ref}, 32'h00000032);
      speed <= 16'sd800; cyc(3);
      rd(A_STATUS); chk("limiting", q[STAT_LIMIT_BIT], 32'h00000001);
      chk("torque cut", {16'h0, trq_ref}, 32'h00000000);
      trq_t <= -16'sd50; cyc(8);
      chk("torque back", {16'h0, trq_ref}, 32'h0000FFCE);
      lim_cfg <= '{os1: 16'h07D0, os2: 16'h07D0, mmax: 16'h0258};
      speed <= 16'sd719; cyc(3);
      chk("mmax below", {31'h0, limiting}, 32'h00000000);
      speed <= 16'sd720; cyc(3);
      chk("mmax at", {31'h0, limiting}, 32'h00000001);
      $display("test limit done");
      stop_test();
   end
endmodule
`default_nettype wire
